// >>> verilog/ealu_core.sv
// Arithmetic and logic datapath: byte, word, logic, bit and multiply ops.
// Assumes the decoder holds start_i only while ready_o is high and
// writes wb_lo_o/wb_hi_o back to the register file when done_o is high.
`timescale 1ns/100ps
`default_nettype none
module ealu_core
#(
    parameter int WIDTH = 8
)
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire ealu_pkg::ealu_op_t op_i,
    input wire logic [4:0] rd_idx_i,
    input wire logic [7:0] rd_lo_i,
    input wire logic [7:0] rd_hi_i,
    input wire logic [7:0] rr_i,
    input wire logic [7:0] imm_i,
    output logic ready_o,
    output logic done_o,
    output logic wb_pair_o,
    output logic [4:0] wb_idx_o,
    output logic [7:0] wb_lo_o,
    output logic [7:0] wb_hi_o,
    output logic [5:0] flags_o
);

    if (WIDTH != ealu_pkg::DATA_W)
    begin : g_width_check
        $error("ealu_core only serves an eight bit datapath");
    end

    typedef struct packed {
        ealu_pkg::ealu_state_t st;
        ealu_pkg::ealu_op_t op;
        logic [4:0] idx;
        logic [7:0] a;
        logic [7:0] hi;
        logic [7:0] rr;
        logic [7:0] imm;
        logic [7:0] res_lo;
        logic [7:0] res_hi;
        logic pair;
        logic done;
        logic [5:0] flags;
    } ealu_regs_t;

    ealu_regs_t s_q;
    ealu_regs_t s_d;
    logic [15:0] prod;
    logic prod_c;
    logic prod_z;
    logic [13:0] byte_out;
    logic word_sub;
    logic [15:0] word_r;
    logic word_v;
    logic word_c;

    // ****************************************************************
    // Operation classes
    // ****************************************************************
    function automatic logic is_long(input ealu_pkg::ealu_op_t op);
        return op inside {ealu_pkg::word_add_immediate, ealu_pkg::word_subtract_immediate,
            ealu_pkg::unsigned_product, ealu_pkg::signed_product,
            ealu_pkg::mixed_sign_product, ealu_pkg::fractional_unsigned_product,
            ealu_pkg::fractional_signed_product, ealu_pkg::fractional_mixed_product};
    endfunction
    function automatic logic is_logic(input ealu_pkg::ealu_op_t op);
        return op inside {ealu_pkg::logic_and, ealu_pkg::conjunction_immediate,
            ealu_pkg::logic_or, ealu_pkg::disjunction_immediate,
            ealu_pkg::exclusive_disjunction, ealu_pkg::bit_set_op,
            ealu_pkg::bit_clear_op, ealu_pkg::zero_minus_check};
    endfunction
    function automatic logic is_mul(input ealu_pkg::ealu_op_t op);
        return is_long(op) && !(op inside {ealu_pkg::word_add_immediate,
            ealu_pkg::word_subtract_immediate});
    endfunction

    // ****************************************************************
    // Single cycle byte unit: returns {flags, result}
    // ****************************************************************
    function automatic logic [13:0] byte_unit(input ealu_pkg::ealu_op_t op,
        input logic [7:0] a, input logic [7:0] rr, input logic [7:0] imm,
        input logic [5:0] f);
        logic [8:0] sum;
        logic [7:0] k;
        logic [7:0] r;
        logic [5:0] nf;
        logic cin;
        logic sub;
        nf = f;
        sum = 9'h000;
        k = (op inside {ealu_pkg::subtract_immediate_op, ealu_pkg::subtract_immediate_borrow,
            ealu_pkg::conjunction_immediate, ealu_pkg::disjunction_immediate,
            ealu_pkg::bit_set_op, ealu_pkg::bit_clear_op}) ? imm : rr;
        cin = (op inside {ealu_pkg::byte_add_carry, ealu_pkg::subtract_with_borrow_op,
            ealu_pkg::subtract_immediate_borrow}) ? f[ealu_pkg::FLAG_C] : 1'b0;
        sub = op inside {ealu_pkg::byte_sub, ealu_pkg::subtract_immediate_op,
            ealu_pkg::subtract_with_borrow_op, ealu_pkg::subtract_immediate_borrow};
        unique case (op)
            ealu_pkg::logic_and, ealu_pkg::conjunction_immediate: r = a & k;
            ealu_pkg::logic_or, ealu_pkg::disjunction_immediate: r = a | k;
            ealu_pkg::exclusive_disjunction: r = a ^ k;
            ealu_pkg::bit_set_op: r = a | k;
            ealu_pkg::bit_clear_op: r = a & ~k;
            ealu_pkg::zero_minus_check: r = a & a;
            default:
            begin
                sum = sub ? ({1'b0, a} - {1'b0, k} - {8'h00, cin})
                          : ({1'b0, a} + {1'b0, k} + {8'h00, cin});
                r = sum[7:0];
            end
        endcase
        nf[ealu_pkg::FLAG_N] = r[7];
        nf[ealu_pkg::FLAG_Z] = (r == 8'h00);
        // Logic forms keep their old carry and half carry
        if (is_logic(op))
            nf[ealu_pkg::FLAG_V] = 1'b0;
        else if (sub)
        begin
            nf[ealu_pkg::FLAG_C] = sum[8];
            nf[ealu_pkg::FLAG_H] = (~a[3] & k[3]) | (k[3] & r[3]) | (r[3] & ~a[3]);
            nf[ealu_pkg::FLAG_V] = (a[7] & ~k[7] & ~r[7]) | (~a[7] & k[7] & r[7]);
            // Borrow forms chain zero across bytes of a longer number
            if (op inside {ealu_pkg::subtract_with_borrow_op,
                ealu_pkg::subtract_immediate_borrow})
                nf[ealu_pkg::FLAG_Z] = (r == 8'h00) & f[ealu_pkg::FLAG_Z];
        end
        else
        begin
            nf[ealu_pkg::FLAG_C] = sum[8];
            nf[ealu_pkg::FLAG_H] = (a[3] & k[3]) | (k[3] & ~r[3]) | (~r[3] & a[3]);
            nf[ealu_pkg::FLAG_V] = (a[7] & k[7] & ~r[7]) | (~a[7] & ~k[7] & r[7]);
        end
        nf[ealu_pkg::FLAG_S] = nf[ealu_pkg::FLAG_N] ^ nf[ealu_pkg::FLAG_V];
        return {nf, r};
    endfunction

    // ****************************************************************
    // Second cycle units, fed from captured operands
    // ****************************************************************
    ealu_mul u_mul
    (
        .a_i(s_q.a),
        .b_i(s_q.rr),
        .a_signed_i(s_q.op inside {ealu_pkg::signed_product, ealu_pkg::mixed_sign_product,
            ealu_pkg::fractional_signed_product, ealu_pkg::fractional_mixed_product}),
        .b_signed_i(s_q.op inside {ealu_pkg::signed_product,
            ealu_pkg::fractional_signed_product}),
        .frac_i(s_q.op inside {ealu_pkg::fractional_unsigned_product,
            ealu_pkg::fractional_signed_product, ealu_pkg::fractional_mixed_product}),
        .prod_o(prod),
        .carry_o(prod_c),
        .zero_o(prod_z)
    );

    // Word arithmetic on the pair, six bit immediate; V and C need only the top bits
    assign word_sub = (s_q.op == ealu_pkg::word_subtract_immediate);
    assign word_r = word_sub
        ? {s_q.hi, s_q.a} - {10'h000, s_q.imm[5:0] & ealu_pkg::WORD_IMM_MASK}
        : {s_q.hi, s_q.a} + {10'h000, s_q.imm[5:0] & ealu_pkg::WORD_IMM_MASK};
    assign word_v = word_sub ? (s_q.hi[7] & ~word_r[15]) : (~s_q.hi[7] & word_r[15]);
    assign word_c = word_sub ? (word_r[15] & ~s_q.hi[7]) : (~word_r[15] & s_q.hi[7]);

    // ****************************************************************
    // Sequencer: short ops finish at the taking edge, long ones one later
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        byte_out = byte_unit(op_i, rd_lo_i, rr_i, imm_i, s_q.flags);
        unique case (s_q.st)
            ealu_pkg::ST_IDLE:
            begin
                if (start_i)
                begin
                    s_d.op = op_i;
                    s_d.idx = rd_idx_i;
                    s_d.a = rd_lo_i;
                    s_d.hi = rd_hi_i;
                    s_d.rr = rr_i;
                    s_d.imm = imm_i;
                    if (is_long(op_i))
                        s_d.st = ealu_pkg::ST_SECOND;
                    else
                    begin
                        // Result and flags land on the same edge
                        s_d.res_lo = byte_out[7:0];
                        s_d.flags = byte_out[13:8];
                        s_d.pair = 1'b0;
                        s_d.done = 1'b1;
                    end
                end
            end
            ealu_pkg::ST_SECOND:
            begin
                s_d.st = ealu_pkg::ST_IDLE;
                s_d.done = 1'b1;
                s_d.pair = 1'b1;
                if (is_mul(s_q.op))
                begin
                    s_d.idx = ealu_pkg::PROD_PAIR_IDX;
                    {s_d.res_hi, s_d.res_lo} = prod;
                    s_d.flags[ealu_pkg::FLAG_C] = prod_c;
                    s_d.flags[ealu_pkg::FLAG_Z] = prod_z;
                end
                else
                begin
                    // Half carry is left alone by the word forms
                    {s_d.res_hi, s_d.res_lo} = word_r;
                    s_d.flags[ealu_pkg::FLAG_N] = word_r[15];
                    s_d.flags[ealu_pkg::FLAG_Z] = (word_r == 16'h0000);
                    s_d.flags[ealu_pkg::FLAG_V] = word_v;
                    s_d.flags[ealu_pkg::FLAG_C] = word_c;
                    s_d.flags[ealu_pkg::FLAG_S] = word_r[15] ^ word_v;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
            s_q.flags <= ealu_pkg::FLAGS_RST;
        end
        else
            s_q <= s_d;
    end

    // Outputs; ready is combinational, data comes from flip-flops
    assign ready_o = (s_q.st == ealu_pkg::ST_IDLE);
    assign done_o = s_q.done;
    assign wb_pair_o = s_q.pair;
    assign wb_idx_o = s_q.idx;
    assign wb_lo_o = s_q.res_lo;
    assign wb_hi_o = s_q.res_hi;
    assign flags_o = s_q.flags;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_SHORT_ONE_CYCLE: assert property (
        start_i && ready_o && !is_long(op_i) |=> done_o && ready_o && !wb_pair_o)
        else $error("short operation did not finish in one cycle");
    AST_LONG_TWO_CYCLES: assert property (
        start_i && ready_o && is_long(op_i) |=> !done_o && !ready_o ##1 done_o && wb_pair_o)
        else $error("two cycle operation timing wrong");
    AST_WORD_SUB_RESULT: assert property (
        done_o && s_q.op == ealu_pkg::word_subtract_immediate |->
        {wb_hi_o, wb_lo_o} == {s_q.hi, s_q.a} - {10'h000, s_q.imm[5:0]})
        else $error("word subtract result wrong");
    AST_WORD_KEEPS_H: assert property (
        done_o && s_q.op inside {ealu_pkg::word_add_immediate,
        ealu_pkg::word_subtract_immediate} |-> $stable(flags_o[ealu_pkg::FLAG_H]))
        else $error("word operation changed half carry");
    AST_LOGIC_KEEPS_CH: assert property (
        done_o && is_logic(s_q.op) |-> $stable(flags_o[ealu_pkg::FLAG_C])
        && $stable(flags_o[ealu_pkg::FLAG_H]) && !flags_o[ealu_pkg::FLAG_V])
        else $error("logic operation touched carry, half carry or overflow");
    AST_BIT_CLEAR: assert property (
        done_o && s_q.op == ealu_pkg::bit_clear_op |-> wb_lo_o == (s_q.a & ~s_q.imm))
        else $error("bit clear result wrong");
    AST_BIT_SET: assert property (
        done_o && s_q.op == ealu_pkg::bit_set_op |-> wb_lo_o == (s_q.a | s_q.imm))
        else $error("bit set result wrong");
    AST_TEST_FLAGS: assert property (
        done_o && s_q.op == ealu_pkg::zero_minus_check |-> wb_lo_o == s_q.a
        && flags_o[ealu_pkg::FLAG_Z] == (s_q.a == 8'h00) && flags_o[ealu_pkg::FLAG_N] == s_q.a[7])
        else $error("test flags wrong");
    AST_PROD_PAIR: assert property (
        done_o && is_mul(s_q.op) |-> wb_idx_o == ealu_pkg::PROD_PAIR_IDX && wb_pair_o
        && $stable(flags_o[ealu_pkg::FLAG_H:ealu_pkg::FLAG_N]))
        else $error("product not in pair zero or wrong flags touched");
    AST_FRAC_SHIFT: assert property (
        done_o && s_q.op == ealu_pkg::fractional_unsigned_product |->
        {wb_hi_o, wb_lo_o} == (({8'h00, s_q.a} * {8'h00, s_q.rr}) << 1))
        else $error("fractional product shift wrong");
    AST_FRAC_LSB: assert property (
        done_o && s_q.op inside {ealu_pkg::fractional_unsigned_product,
        ealu_pkg::fractional_signed_product, ealu_pkg::fractional_mixed_product}
        |-> !wb_lo_o[0])
        else $error("fractional product low bit set");
    AST_SIGN_RELATION: assert property (
        done_o && !is_mul(s_q.op) |->
        flags_o[ealu_pkg::FLAG_S] == (flags_o[ealu_pkg::FLAG_N] ^ flags_o[ealu_pkg::FLAG_V]))
        else $error("sign flag is not N xor V");
    AST_FLAGS_WITH_WB: assert property (
        !done_o |=> done_o || $stable(flags_o))
        else $error("flags changed without a write back");
    COV_BYTE_ADD: cover property (start_i && ready_o && op_i == ealu_pkg::byte_add_carry);
    COV_WORD_ADD: cover property (done_o && s_q.op == ealu_pkg::word_add_immediate);
    COV_SIGNED_MUL: cover property (done_o && s_q.op == ealu_pkg::signed_product);
    COV_BACK_TO_BACK: cover property (done_o && start_i && ready_o);

endmodule
`default_nettype wire

// >>> verilog/ealu_pkg.sv
// Shared constants and types of the eight bit arithmetic and logic unit.
// Assumes one core clock and a decoder that supplies decoded operations.
// Contract
// - Word add immediate: flags ZCNVS, two cycles
// - Word subtract immediate: flags ZCNVS, two cycles
// - Byte add/subtract: one cycle, all six flags
// - AND/OR/XOR: one cycle, ZNVS only
// - Bit set ORs mask, logical flags
// - Bit clear ANDs inverted mask, ZNVS
// - Test ANDs register with itself, ZNVS
// - Products go to pair one/zero, ZC, two cycles
// - Fractional products shift left one first
package ealu_pkg;

    // ****************************************************************
    // Status flag positions and reset value
    // ****************************************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_W = 6;
    localparam logic [5:0] FLAGS_RST = 6'h00;

    // ****************************************************************
    // Register file and timing constants
    // ****************************************************************
    localparam int DATA_W = 8;
    localparam logic [4:0] PROD_PAIR_IDX = 5'h00;
    localparam logic [5:0] WORD_IMM_MASK = 6'h3f;
    localparam int SHORT_CYCLES = 1;
    localparam int LONG_CYCLES = 2;

    // ****************************************************************
    // Operations and sequencer states
    // ****************************************************************
    typedef enum logic [4:0] {
        byte_add, byte_add_carry, byte_sub, subtract_immediate_op,
        subtract_with_borrow_op, subtract_immediate_borrow,
        word_add_immediate, word_subtract_immediate,
        logic_and, conjunction_immediate, logic_or, disjunction_immediate,
        exclusive_disjunction, bit_set_op, bit_clear_op, zero_minus_check,
        unsigned_product, signed_product, mixed_sign_product,
        fractional_unsigned_product, fractional_signed_product,
        fractional_mixed_product
    } ealu_op_t;

    typedef enum logic {
        ST_IDLE,
        ST_SECOND
    } ealu_state_t;

endpackage

// >>> verilog/ealu_mul.sv
// Combinational 8x8 multiplier with signed, mixed and fractional forms.
// Assumes the caller registers operands and result around it.
`timescale 1ns/100ps
`default_nettype none
module ealu_mul
(
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic a_signed_i,
    input wire logic b_signed_i,
    input wire logic frac_i,
    output logic [15:0] prod_o,
    output logic carry_o,
    output logic zero_o
);

    logic signed [8:0] a_ext;
    logic signed [8:0] b_ext;
    logic signed [17:0] full;
    logic [15:0] raw;

    // ****************************************************************
    // Product, shift and flags
    // ****************************************************************
    // Nine bit extension lets one signed multiplier serve all three forms
    always_comb
    begin
        a_ext = $signed({a_signed_i & a_i[7], a_i});
        b_ext = $signed({b_signed_i & b_i[7], b_i});
        full = a_ext * b_ext;
        raw = full[15:0];
        // Carry is bit 15 before the fractional shift
        carry_o = raw[15];
        prod_o = frac_i ? {raw[14:0], 1'b0} : raw;
        zero_o = (prod_o == 16'h0000);
    end

endmodule
`default_nettype wire

// >>> verif/ealu_regfile_model.sv
// Behavioural working register file standing beside the arithmetic unit.
// Assumes the core clock and takes write-back only while done is high.
`timescale 1ns/100ps
`default_nettype none
module ealu_regfile_model
(
    input wire logic mclk_i,
    input wire logic done_i,
    input wire logic wb_pair_i,
    input wire logic [4:0] wb_idx_i,
    input wire logic [7:0] wb_lo_i,
    input wire logic [7:0] wb_hi_i,
    input wire logic [4:0] rd_sel_i,
    output logic [15:0] pair_o
);
    // ****************************************************************
    // Storage and write-back
    // ****************************************************************
    logic [7:0] regs [32];

    // Write only on done; wb_* hold stale values between pulses
    always @(posedge mclk_i)
    begin
        if (done_i === 1'b1)
        begin
            regs[wb_idx_i] <= wb_lo_i;
            if (wb_pair_i === 1'b1)
            begin
                regs[wb_idx_i + 5'h01] <= wb_hi_i;
            end
        end
    end

    // Pair view, high byte from the next index up
    assign pair_o = {regs[rd_sel_i + 5'h01], regs[rd_sel_i]};
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench of the arithmetic unit with a register file model.
// Assumes ealu_pkg is compiled first; inputs change 1 ns after the edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    // ****************************************************************
    // Signals, clock and instances
    // ****************************************************************
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic start_i = 1'b0;
    ealu_pkg::ealu_op_t op_i = ealu_pkg::byte_add;
    logic [4:0] rd_idx_i = 5'h1a;
    logic [7:0] rd_lo_i = 8'h00, rd_hi_i = 8'h00, rr_i = 8'h00, imm_i = 8'h00;
    logic ready_o, done_o, wb_pair_o;
    logic [4:0] wb_idx_o;
    logic [7:0] wb_lo_o, wb_hi_o;
    logic [5:0] flags_o;
    logic [15:0] pair_view;
    logic [4:0] rd_sel = 5'h00;
    int fail_count = 0;
    int comparisons = 0;
    int cycle_count = 0;
    logic [5:0] exp_f = 6'h00;

    // Free-running core clock, 10 ns period
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end

    ealu_core #(.WIDTH(8)) ealu_core_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .start_i(start_i), .op_i(op_i), .rd_idx_i(rd_idx_i), .rd_lo_i(rd_lo_i),
        .rd_hi_i(rd_hi_i), .rr_i(rr_i), .imm_i(imm_i), .ready_o(ready_o),
        .done_o(done_o), .wb_pair_o(wb_pair_o), .wb_idx_o(wb_idx_o), .wb_lo_o(wb_lo_o),
        .wb_hi_o(wb_hi_o), .flags_o(flags_o));

    ealu_regfile_model ealu_regfile_model_i (.mclk_i(mclk_i), .done_i(done_o),
        .wb_pair_i(wb_pair_o), .wb_idx_i(wb_idx_o), .wb_lo_i(wb_lo_o),
        .wb_hi_i(wb_hi_o), .rd_sel_i(rd_sel), .pair_o(pair_view));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict();
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Issue one op at edge+1 and check timing, target and flags;
    // start stays high after short ops so callers can go back to back
    task automatic run_op(input ealu_pkg::ealu_op_t op, input logic [7:0] lo, hi, rr,
        imm, input logic [15:0] er, input logic [5:0] ef);
        logic long_op;
        long_op = op inside {ealu_pkg::word_add_immediate, ealu_pkg::word_subtract_immediate,
            [ealu_pkg::unsigned_product:ealu_pkg::fractional_mixed_product]};
        op_i = op;
        rd_lo_i = lo;
        rd_hi_i = hi;
        rr_i = rr;
        imm_i = imm;
        start_i = 1'b1;
        @(posedge mclk_i);
        #1;
        if (long_op)
        begin
            start_i = 1'b0;
            `CHK({ready_o, done_o}, 2'b00)
            @(posedge mclk_i);
            #1;
        end
        `CHK({done_o, ready_o, wb_pair_o}, {2'b11, long_op})
        `CHK(wb_idx_o, (op >= ealu_pkg::unsigned_product) ? 5'h00 : rd_idx_i)
        `CHK(wb_lo_o, er[7:0])
        if (long_op)
            `CHK(wb_hi_o, er[15:8])
        `CHK(flags_o, ef)
        exp_f = ef;
    endtask

    // Drop the request and see done fall after its single cycle
    task automatic stop_ops();
        start_i = 1'b0;
        @(posedge mclk_i);
        #1;
        `CHK(done_o, 1'b0)
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_byte_arith();
        run_op(ealu_pkg::byte_add, 8'h0f, 8'h00, 8'h01, 8'hee, 16'h10, 6'h20);
        run_op(ealu_pkg::byte_add, 8'h80, 8'h00, 8'h80, 8'hee, 16'h00, 6'h1b);
        run_op(ealu_pkg::subtract_with_borrow_op, 8'h10, 8'h00, 8'h0f, 8'hee, 16'h00, 6'h22);
        run_op(ealu_pkg::subtract_immediate_borrow, 8'h00, 8'h00, 8'hee, 8'h00, 16'h00, 6'h02);
        run_op(ealu_pkg::byte_sub, 8'h00, 8'h00, 8'h01, 8'hee, 16'hff, 6'h35);
        run_op(ealu_pkg::byte_add_carry, 8'h7f, 8'h00, 8'h00, 8'hee, 16'h80, 6'h2c);
        run_op(ealu_pkg::subtract_immediate_op, 8'h80, 8'h00, 8'hee, 8'h01, 16'h7f, 6'h38);
        stop_ops();
    endtask

    // Only imm bits 5:0 count; half carry must survive both word ops
    task automatic test_word_ops();
        run_op(ealu_pkg::word_add_immediate, 8'hff, 8'h7f, 8'hee, 8'hc1, 16'h8000, 6'h2c);
        run_op(ealu_pkg::word_subtract_immediate, 8'h00, 8'h00, 8'hee, 8'h3f, 16'hffc1, 6'h35);
        run_op(ealu_pkg::word_subtract_immediate, 8'h01, 8'h00, 8'hee, 8'h01, 16'h0000, 6'h22);
        rd_sel = rd_idx_i;
        stop_ops();
        `CHK(pair_view, 16'h0000)
    endtask

    // Logic, bit and test ops back to back; C and H carried over
    task automatic test_logic_ops();
        ealu_pkg::ealu_op_t ops [8];
        logic [7:0] r;
        ops = '{ealu_pkg::logic_and, ealu_pkg::conjunction_immediate, ealu_pkg::logic_or,
            ealu_pkg::disjunction_immediate, ealu_pkg::exclusive_disjunction,
            ealu_pkg::bit_set_op, ealu_pkg::bit_clear_op, ealu_pkg::zero_minus_check};
        foreach (ops[i])
        begin
            case (i)
                0: r = 8'ha5 & 8'h3c;
                1: r = 8'ha5 & 8'h0f;
                2: r = 8'ha5 | 8'h3c;
                3, 5: r = 8'ha5 | 8'h0f;
                4: r = 8'ha5 ^ 8'h3c;
                6: r = 8'ha5 & ~8'h0f;
                default: r = 8'ha5;
            endcase
            run_op(ops[i], 8'ha5, 8'h00, 8'h3c, 8'h0f, {8'h00, r},
                {exp_f[5], r[7], 1'b0, r[7], r == 8'h00, exp_f[0]});
        end
        run_op(ealu_pkg::exclusive_disjunction, 8'h5a, 8'h00, 8'h5a, 8'hee, 16'h0000,
            {exp_f[5], 4'b0001, exp_f[0]});
        stop_ops();
    endtask

    // All six products: signedness, shift, carry before shift, pair 1:0
    task automatic test_products();
        logic [15:0] pa, pb, p, s;
        for (int k = 0; k < 7; k++)
        begin
            pa = (k % 3 != 0) ? {{8{1'b1}}, 8'h80} : 16'h0080;
            pb = (k % 3 == 1) ? 16'hffff : 16'h00ff;
            if (k == 6)
                pa = 16'h0000;
            p = pa * pb;
            s = (k >= 3 && k < 6) ? {p[14:0], 1'b0} : p;
            run_op(ealu_pkg::ealu_op_t'(16 + (k % 6)), pa[7:0], 8'hee, 8'hff, 8'hee, s,
                {exp_f[5:2], s == 16'h0000, p[15]});
        end
        rd_sel = 5'h00;
        stop_ops();
        `CHK(pair_view, 16'h0000)
    endtask

    // A request during the second product cycle must be ignored
    task automatic test_refused();
        op_i = ealu_pkg::unsigned_product;
        rd_lo_i = 8'h10;
        rr_i = 8'h10;
        start_i = 1'b1;
        @(posedge mclk_i);
        #1;
        op_i = ealu_pkg::byte_add;
        `CHK(ready_o, 1'b0)
        @(posedge mclk_i);
        #1;
        start_i = 1'b0;
        `CHK({done_o, wb_hi_o, wb_lo_o}, 17'h10100)
        @(posedge mclk_i);
        #1;
        `CHK({done_o, flags_o}, {1'b0, exp_f[5:2], 2'b00})
    endtask

    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    initial
    begin
        repeat (12) @(posedge mclk_i);
        #1;
        `CHK({ready_o, done_o, flags_o, wb_lo_o}, 16'h8000)
        rst_n_i = 1'b1;
        test_byte_arith();
        test_word_ops();
        test_logic_ops();
        test_products();
        test_refused();
        give_verdict();
    end

    // Whole run needs well under 200 cycles
    always @(posedge mclk_i)
    begin
        cycle_count++;
        if (cycle_count == 2000)
        begin
            fail_count++;
            give_verdict();
        end
    end
endmodule
`undef CHK
`default_nettype wire
